// >>> hdl/fplr_cmd_core.sv
`timescale 1ns/1ps
module fplr_cmd_core #(
    parameter int PROG_CYC = fplr_pkg::PROG_CYCLES
) (
    // System
    input  wire logic        clk,
    input  wire logic        rst,
    // Serial link
    input  wire logic        sck,
    input  wire logic        cs_n,
    input  wire logic        data_line_0,
    output logic             so,
    output logic             so_oe_n,
    // Configuration, same clock as clk
    input  wire logic [15:0] protection_config_reg,
    input  wire logic        cfg_wr,
    input  wire logic [7:0]  cfg_wdata,
    input  wire logic        bp_wr,
    input  wire logic [2:0]  bp_wdata,
    input  wire logic        cont_read_enter,
    input  wire logic        prog_fail,
    // Status
    output logic             write_in_progress,
    output logic             write_enable_latch,
    output logic             prog_err,
    output logic             lock_bit,
    output logic [7:0]       config_reg_one,
    output logic [2:0]       block_protect,
    output logic             cont_read
);

    // Link domain
    logic        start_q;
    logic [7:0]  cnt_q;
    logic [5:0]  pos_q;
    logic [7:0]  op_q;
    logic [63:0] sr_q;
    logic        tog_q;
    logic        pm_s1_q;
    logic        pm_s2_q;
    logic        so_q;
    logic        so_oe_n_q;

    // System domain
    logic        cs_s1_q;
    logic        cs_s2_q;
    logic        cs_s3_q;
    logic        tg_s1_q;
    logic        tg_s2_q;
    logic        seen_q;
    fplr_pkg::fplr_state_t state_q;
    logic [16:0] timer_q;
    logic        wip_q;
    logic        wel_q;
    logic        perr_q;
    logic        lock_q;
    logic [63:0] pw_q;
    logic [63:0] data_q;
    logic [7:0]  cfg_q;
    logic [2:0]  bp_q;
    logic        cr_q;

    logic [63:0] pw_in;
    logic        fe;
    logic        len8;
    logic        len72;
    logic        idle;
    logic        pw_mode;
    logic        tdone;
    logic        go_write_enable_cmd;
    logic        go_clear_status_cmd;
    logic        go_swrst;
    logic        go_mbr;
    logic        go_lclr;
    logic        go_pprog;
    logic        go_unlk;
    logic        lclr_done;
    logic        pprog_done;
    logic        unlk_done;
    logic        unlk_match;

    // Set while deselected so the first edge of a frame restarts the count
    always_ff @(posedge sck or posedge cs_n) begin
        if (cs_n) begin
            start_q <= 1'b1;
        end else begin
            start_q <= 1'b0;
        end
    end

    // Saturating count of rising edges in the frame
    always_ff @(posedge sck) begin
        if (start_q) begin
            cnt_q <= 8'h01;
        end else if (cnt_q != fplr_pkg::CNT_MAX) begin
            cnt_q <= cnt_q + 8'h01;
        end
    end

    // Data bit position, wraps so reads repeat
    always_ff @(posedge sck) begin
        if (start_q) begin
            pos_q <= 6'h00;
        end else if (cnt_q >= fplr_pkg::INST_BITS) begin
            pos_q <= pos_q + 6'h01;
        end
    end

    always_ff @(posedge sck) begin
        if (start_q) begin
            op_q <= {7'h00, data_line_0};
        end else if (cnt_q < fplr_pkg::INST_BITS) begin
            op_q <= {op_q[6:0], data_line_0};
        end
    end

    always_ff @(posedge sck) begin
        if (!start_q && cnt_q >= fplr_pkg::INST_BITS) begin
            sr_q <= {sr_q[62:0], data_line_0};
        end
    end

    // Frame marker; link clock may be stopped, so reset acts without it
    always_ff @(posedge sck or posedge rst) begin
        if (rst) begin
            tog_q <= 1'b0;
        end else if (start_q) begin
            tog_q <= ~tog_q;
        end
    end

    always_ff @(posedge sck) begin
        pm_s1_q <= protection_config_reg[fplr_pkg::PW_MODE_BIT];
        pm_s2_q <= pm_s1_q;
    end

    // Lock bit and password are only changed between frames, so they are
    // read here without a crossing
    always_ff @(negedge sck or posedge cs_n) begin
        if (cs_n) begin
            so_q      <= 1'b0;
            so_oe_n_q <= 1'b1;
        end else if (cnt_q >= fplr_pkg::INST_BITS
                     && op_q == fplr_pkg::LOCK_REG_READ_CMD) begin
            so_q      <= ({7'h00, lock_q} >> ~pos_q[2:0]) != 8'h00;
            so_oe_n_q <= 1'b0;
        end else if (cnt_q >= fplr_pkg::INST_BITS && pm_s2_q
                     && op_q == fplr_pkg::PASSWORD_READ_CMD) begin
            so_q      <= pw_q[{pos_q[5:3], ~pos_q[2:0]}];
            so_oe_n_q <= 1'b0;
        end else begin
            so_q      <= 1'b0;
            so_oe_n_q <= 1'b1;
        end
    end

    // Chip select rise and frame marker into the system domain
    always_ff @(posedge clk) begin
        if (rst) begin
            cs_s1_q <= 1'b1;
            cs_s2_q <= 1'b1;
            cs_s3_q <= 1'b1;
            tg_s1_q <= 1'b0;
            tg_s2_q <= 1'b0;
            seen_q  <= 1'b0;
        end else begin
            cs_s1_q <= cs_n;
            cs_s2_q <= cs_s1_q;
            cs_s3_q <= cs_s2_q;
            tg_s1_q <= tog_q;
            tg_s2_q <= tg_s1_q;
            if (cs_s2_q && !cs_s3_q) begin
                seen_q <= tg_s2_q;
            end
        end
    end

    // Low byte arrives first, so byte k sits at the top of the shifter minus k
    always_comb begin
        pw_in = 64'h0;
        for (int k = 0; k < 8; k++) begin
            pw_in[8*k +: 8] = sr_q[56-8*k +: 8];
        end
    end

    // Shift state is static once the link clock stops with chip select high
    assign fe      = cs_s2_q && !cs_s3_q && (tg_s2_q != seen_q);
    assign len8    = cnt_q == fplr_pkg::INST_BITS;
    assign len72   = cnt_q == fplr_pkg::PW_FRAME_BITS;
    assign idle    = state_q == fplr_pkg::ST_IDLE;
    assign pw_mode = !protection_config_reg[fplr_pkg::PW_MODE_BIT];
    assign tdone   = timer_q == 17'h0;

    assign go_mbr   = fe && len8 && op_q == fplr_pkg::MODE_BITS_CLEAR_CMD;
    assign go_write_enable_cmd  = fe && !cr_q && len8 && idle
                      && op_q == fplr_pkg::WRITE_ENABLE_CMD;
    assign go_clear_status_cmd  = fe && !cr_q && len8
                      && op_q == fplr_pkg::CLEAR_STATUS_CMD;
    assign go_swrst = fe && !cr_q && len8 && state_q != fplr_pkg::ST_SW_RST
                      && op_q == fplr_pkg::SOFT_RESET_CMD;
    assign go_lclr  = fe && !cr_q && len8 && idle && wel_q
                      && op_q == fplr_pkg::LOCK_REG_CLEAR_CMD;
    assign go_pprog = fe && !cr_q && len72 && idle && wel_q && !pw_mode
                      && op_q == fplr_pkg::PASSWORD_PROGRAM_CMD;
    assign go_unlk  = fe && !cr_q && len72 && idle
                      && op_q == fplr_pkg::PASSWORD_UNLOCK_CMD;

    assign lclr_done  = state_q == fplr_pkg::ST_LOCK_CLR && tdone;
    assign pprog_done = state_q == fplr_pkg::ST_PASS_PROG && tdone;
    assign unlk_done  = state_q == fplr_pkg::ST_UNLOCK && tdone;
    assign unlk_match = data_q == pw_q;

    // Operation sequencer and busy flag
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= fplr_pkg::ST_IDLE;
            timer_q <= 17'h0;
            wip_q   <= 1'b0;
        end else if (go_swrst) begin
            state_q <= fplr_pkg::ST_SW_RST;
            timer_q <= 17'(fplr_pkg::RPH_CYCLES - 1);
            wip_q   <= 1'b1;
        end else begin
            case (state_q)
                fplr_pkg::ST_IDLE: begin
                    if (go_lclr) begin
                        state_q <= fplr_pkg::ST_LOCK_CLR;
                        timer_q <= 17'(PROG_CYC - 1);
                        wip_q   <= 1'b1;
                    end else if (go_pprog) begin
                        state_q <= fplr_pkg::ST_PASS_PROG;
                        timer_q <= 17'(PROG_CYC - 1);
                        wip_q   <= 1'b1;
                    end else if (go_unlk) begin
                        state_q <= fplr_pkg::ST_UNLOCK;
                        timer_q <= 17'(fplr_pkg::UNLOCK_CYCLES - 1);
                        wip_q   <= 1'b1;
                    end
                end
                fplr_pkg::ST_LOCK_CLR,
                fplr_pkg::ST_PASS_PROG,
                fplr_pkg::ST_SW_RST: begin
                    if (tdone) begin
                        state_q <= fplr_pkg::ST_IDLE;
                        wip_q   <= 1'b0;
                    end else begin
                        timer_q <= timer_q - 17'h1;
                    end
                end
                fplr_pkg::ST_UNLOCK: begin
                    if (tdone && unlk_match) begin
                        state_q <= fplr_pkg::ST_IDLE;
                        wip_q   <= 1'b0;
                    end else if (tdone) begin
                        state_q <= fplr_pkg::ST_UNLOCK_FAIL;
                    end else begin
                        timer_q <= timer_q - 17'h1;
                    end
                end
                fplr_pkg::ST_UNLOCK_FAIL: begin
                    if (go_clear_status_cmd) begin
                        state_q <= fplr_pkg::ST_IDLE;
                        wip_q   <= 1'b0;
                    end
                end
                default: begin
                    state_q <= fplr_pkg::ST_IDLE;
                    wip_q   <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (go_pprog || go_unlk) begin
            data_q <= pw_in;
        end
    end

    // Write enable latch
    always_ff @(posedge clk) begin
        if (rst || go_swrst) begin
            wel_q <= 1'b0;
        end else if (lclr_done || pprog_done) begin
            wel_q <= 1'b0;
        end else if (go_write_enable_cmd) begin
            wel_q <= 1'b1;
        end
    end

    // Program error; a failure wins over a clear arriving in the same cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            perr_q <= 1'b0;
        end else if (unlk_done && !unlk_match) begin
            perr_q <= 1'b1;
        end else if (pprog_done && prog_fail) begin
            perr_q <= 1'b1;
        end else if (go_swrst || go_clear_status_cmd) begin
            perr_q <= 1'b0;
        end
    end

    // Lock bit survives software reset
    always_ff @(posedge clk) begin
        if (rst) begin
            lock_q <= !pw_mode;
        end else if (lclr_done) begin
            lock_q <= 1'b0;
        end else if (unlk_done && unlk_match) begin
            lock_q <= 1'b1;
        end
    end

    // Flash programming can only clear bits
    always_ff @(posedge clk) begin
        if (rst) begin
            pw_q <= fplr_pkg::PW_RESET;
        end else if (pprog_done) begin
            pw_q <= pw_q & data_q;
        end
    end

    // Freeze only sets; it and the other config bits ignore software reset
    always_ff @(posedge clk) begin
        if (rst) begin
            cfg_q <= fplr_pkg::CFG_RESET;
        end else if (cfg_wr) begin
            cfg_q <= cfg_wdata | (cfg_q & (8'h01 << fplr_pkg::FREEZE_BIT));
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            bp_q <= fplr_pkg::BP_RESET;
        end else if (go_swrst && cfg_q[fplr_pkg::BLOCK_PROTECT_VOLATILE_SEL_BIT]
                     && !cfg_q[fplr_pkg::FREEZE_BIT]) begin
            bp_q <= fplr_pkg::BP_RESET;
        end else if (bp_wr && !cfg_q[fplr_pkg::FREEZE_BIT]) begin
            bp_q <= bp_wdata;
        end
    end

    // Entry wins over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            cr_q <= 1'b0;
        end else if (cont_read_enter) begin
            cr_q <= 1'b1;
        end else if (go_mbr || go_swrst) begin
            cr_q <= 1'b0;
        end
    end

    assign so                 = so_q;
    assign so_oe_n            = so_oe_n_q;
    assign write_in_progress  = wip_q;
    assign write_enable_latch = wel_q;
    assign prog_err           = perr_q;
    assign lock_bit           = lock_q;
    assign config_reg_one     = cfg_q;
    assign block_protect      = bp_q;
    assign cont_read          = cr_q;

endmodule : fplr_cmd_core

// >>> hdl/fplr_pkg.sv
package fplr_pkg;
    localparam logic [7:0] LOCK_REG_READ_CMD     = 8'ha7;
    localparam logic [7:0] LOCK_REG_CLEAR_CMD    = 8'ha6;
    localparam logic [7:0] PASSWORD_READ_CMD     = 8'he7;
    localparam logic [7:0] PASSWORD_PROGRAM_CMD  = 8'he8;
    localparam logic [7:0] PASSWORD_UNLOCK_CMD   = 8'he9;
    localparam logic [7:0] SOFT_RESET_CMD        = 8'hf0;
    localparam logic [7:0] MODE_BITS_CLEAR_CMD   = 8'hff;
    localparam logic [7:0] WRITE_ENABLE_CMD      = 8'h06;
    localparam logic [7:0] CLEAR_STATUS_CMD      = 8'h30;

    localparam logic [7:0] INST_BITS      = 8'h08;
    localparam logic [7:0] PW_FRAME_BITS  = 8'h48;
    localparam logic [7:0] CNT_MAX        = 8'hff;

    localparam int PW_MODE_BIT = 2;
    localparam int FREEZE_BIT  = 1;
    localparam int BLOCK_PROTECT_VOLATILE_SEL_BIT    = 3;

    localparam logic [63:0] PW_RESET  = 64'hffff_ffff_ffff_ffff;
    localparam logic [2:0]  BP_RESET  = 3'h0;
    localparam logic [7:0]  CFG_RESET = 8'h00;

    localparam int CLK_PERIOD_NS  = 10;
    localparam int PROG_TIME_US   = 750;
    localparam int UNLOCK_TIME_NS = 1000;
    localparam int RPH_TIME_US    = 35;
    localparam int PROG_CYCLES    = PROG_TIME_US * 1000 / CLK_PERIOD_NS;
    localparam int UNLOCK_CYCLES  = UNLOCK_TIME_NS / CLK_PERIOD_NS;
    localparam int RPH_CYCLES     = (RPH_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_LOCK_CLR,
        ST_PASS_PROG,
        ST_UNLOCK,
        ST_UNLOCK_FAIL,
        ST_SW_RST
    } fplr_state_t;
endpackage : fplr_pkg

// >>> verif/fplr_cmd_core_sva.sv
`timescale 1ns/1ps
module fplr_cmd_core_sva #(
    parameter int PROG_CYC = 50
) (
    // Clock and reset
    input wire logic       clk,
    input wire logic       rst,
    // Link
    input wire logic       cs_n,
    input wire logic       so_oe_n,
    // Configuration
    input wire logic       cfg_wr,
    // Status
    input wire logic       write_in_progress,
    input wire logic       write_enable_latch,
    input wire logic       prog_err,
    input wire logic       lock_bit,
    input wire logic [7:0] config_reg_one,
    input wire logic [2:0] block_protect,
    input wire logic       cont_read
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // Stuck unlock state excluded, it waits on the host
    logic [15:0] busy_cnt_q;
    always_ff @(posedge clk) begin
        if (rst || !write_in_progress || prog_err) begin
            busy_cnt_q <= 16'h0000;
        end else begin
            busy_cnt_q <= busy_cnt_q + 16'h0001;
        end
    end

    a_lock_clear_done: assert property (
        $fell(lock_bit) |-> $fell(write_in_progress) && !write_enable_latch)
        else $error("Lock bit fell outside a finished clear");
    a_unlock_sets_lock: assert property (
        $rose(lock_bit) |-> $fell(write_in_progress) && !prog_err)
        else $error("Lock bit rose outside a good unlock");
    a_err_keeps_busy: assert property (
        prog_err && write_in_progress |=> write_in_progress || !prog_err)
        else $error("Busy dropped while error still set");
    a_busy_min_span: assert property (
        $rose(write_in_progress) |-> write_in_progress[*8])
        else $error("Busy flag too short");
    a_busy_bounded: assert property (
        busy_cnt_q <= 16'(fplr_pkg::RPH_CYCLES + 8))
        else $error("Busy flag never ends");
    a_out_idle_off: assert property (
        cs_n |-> so_oe_n)
        else $error("Output driven while deselected");
    a_cont_read_blocks: assert property (
        cont_read && !write_in_progress |=> !$rose(write_enable_latch)
            && !$rose(write_in_progress))
        else $error("Command taken in continuous read");
    a_cfg_kept: assert property (
        !cfg_wr |=> $stable(config_reg_one))
        else $error("Configuration changed without a write");
    a_bp_frozen: assert property (
        config_reg_one[1] |=> $stable(block_protect))
        else $error("Block protect moved while frozen");

    c_lock_clear: cover property ($fell(lock_bit));
    c_unlock_ok: cover property ($rose(lock_bit));
    c_unlock_bad: cover property ($rose(prog_err) && write_in_progress);
    c_cont_exit: cover property ($fell(cont_read));
endmodule : fplr_cmd_core_sva

bind fplr_cmd_core fplr_cmd_core_sva #(.PROG_CYC(PROG_CYC)) u_fplr_cmd_core_sva (
    .clk(clk), .rst(rst), .cs_n(cs_n), .so_oe_n(so_oe_n), .cfg_wr(cfg_wr),
    .write_in_progress(write_in_progress), .write_enable_latch(write_enable_latch),
    .prog_err(prog_err), .lock_bit(lock_bit), .config_reg_one(config_reg_one),
    .block_protect(block_protect), .cont_read(cont_read)
);

// >>> verif/fplr_host_model.sv
`timescale 1ns/1ps
module fplr_host_model (
    // Link
    output logic     sck,
    output logic     cs_n,
    output logic     data_line_0,
    input wire logic so,
    input wire logic so_oe_n
);
    logic oe_seen;

    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        data_line_0 = 1'b0;
        oe_seen = 1'b0;
    end

    // Clock stands low between frames; 64 ns period
    task automatic frame(input logic [7:0] op, input logic [63:0] d, input int nb,
                         output logic [63:0] rx);
        int i;
        int k;
        rx = 64'h0;
        oe_seen = 1'b0;
        cs_n = 1'b0;
        #20;
        for (i = 0; i < 8 + nb; i++) begin
            k = (i < 8) ? 0 : ((i - 8) / 8) * 8 + 7 - (i - 8) % 8;
            data_line_0 = (i < 8) ? op[7 - i] : d[k];
            #32 sck = 1'b1;
            if (i >= 8) begin
                rx[k] = so;
            end
            oe_seen = oe_seen | ~so_oe_n;
            #32 sck = 1'b0;
        end
        #20 cs_n = 1'b1;
        // Released line shows the inverse, not a stale value
        data_line_0 = ~data_line_0;
        #100;
    endtask : frame
endmodule : fplr_host_model

// >>> verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    localparam logic [63:0] PW = 64'h0123_4567_89ab_cdef;
    logic clk;
    logic rst;
    logic sck;
    logic cs_n;
    logic data_line_0;
    logic so;
    logic so_oe_n;
    logic [15:0] protection_config_reg;
    logic cfg_wr;
    logic [7:0] cfg_wdata;
    logic bp_wr;
    logic [2:0] bp_wdata;
    logic cont_read_enter;
    logic prog_fail;
    logic write_in_progress;
    logic write_enable_latch;
    logic prog_err;
    logic lock_bit;
    logic [7:0] config_reg_one;
    logic [2:0] block_protect;
    logic cont_read;
    logic [63:0] rx;
    int failures = 0;
    int checks_done = 0;

    fplr_cmd_core #(.PROG_CYC(50)) u_fplr_cmd_core (
        .clk(clk), .rst(rst), .sck(sck), .cs_n(cs_n), .data_line_0(data_line_0),
        .so(so), .so_oe_n(so_oe_n), .protection_config_reg(protection_config_reg),
        .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata), .bp_wr(bp_wr), .bp_wdata(bp_wdata),
        .cont_read_enter(cont_read_enter), .prog_fail(prog_fail),
        .write_in_progress(write_in_progress), .write_enable_latch(write_enable_latch),
        .prog_err(prog_err), .lock_bit(lock_bit), .config_reg_one(config_reg_one),
        .block_protect(block_protect), .cont_read(cont_read)
    );
    fplr_host_model u_fplr_host_model (
        .sck(sck), .cs_n(cs_n), .data_line_0(data_line_0), .so(so), .so_oe_n(so_oe_n)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic summarize();
        $display("checks=%0d failures=%0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : summarize

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic cmd(input logic [7:0] op, input logic [63:0] d = 64'h0, input int nb = 0);
        u_fplr_host_model.frame(op, d, nb, rx);
        // Realign to the falling clock edge so outputs are settled when looked at
        @(negedge clk);
    endtask : cmd

    // Bounded poll; soft reset recovery is the longest wait
    task automatic idle();
        int n;
        for (n = 0; n < 5000 && write_in_progress !== 1'b0; n++) begin
            @(negedge clk);
        end
        if (n == 5000) begin
            failures++;
        end
    endtask : idle

    task automatic do_reset(input logic [15:0] pcr);
        @(negedge clk);
        rst = 1'b1;
        protection_config_reg = pcr;
        repeat (12) @(negedge clk);
        rst = 1'b0;
    endtask : do_reset

    task automatic load(input logic [7:0] c, input logic [2:0] b);
        @(negedge clk);
        cfg_wr = 1'b1;
        cfg_wdata = c;
        @(negedge clk);
        cfg_wr = 1'b0;
        bp_wr = 1'b1;
        bp_wdata = b;
        @(negedge clk);
        bp_wr = 1'b0;
    endtask : load

    initial begin
        #600000;
        failures++;
        summarize();
    end

    initial begin
        rst = 1'b1;
        {cfg_wr, cfg_wdata, bp_wr, bp_wdata, cont_read_enter, prog_fail} = '0;
        do_reset(16'hffff);
        check(lock_bit, 1'b1);
        cmd(8'ha7, 64'h0, 16);
        check(rx[15:0], 16'h0101);
        cmd(8'ha6);
        check({write_in_progress, lock_bit}, 2'b01);
        cmd(8'h06);
        cmd(8'ha6, 64'h0, 1);
        check({write_in_progress, write_enable_latch}, 2'b01);
        cmd(8'ha6);
        check(write_in_progress, 1'b1);
        idle();
        check({lock_bit, write_enable_latch}, 2'b00);
        cmd(8'ha7, 64'h0, 16);
        check(rx[15:0], 16'h0000);
        cmd(8'he8, PW, 64);
        check(write_in_progress, 1'b0);
        cmd(8'h06);
        cmd(8'he8, PW, 64);
        check(write_in_progress, 1'b1);
        idle();
        check({write_enable_latch, prog_err}, 2'b00);
        cmd(8'he7, 64'h0, 64);
        check(rx, PW);
        cmd(8'he9, PW, 63);
        check(write_in_progress, 1'b0);
        cmd(8'he9, ~PW, 64);
        repeat (150) @(negedge clk);
        check({write_in_progress, prog_err}, 2'b11);
        cmd(8'h30);
        check({write_in_progress, prog_err}, 2'b00);
        cmd(8'he9, PW, 64);
        check(write_in_progress, 1'b1);
        idle();
        check(lock_bit, 1'b1);
        prog_fail = 1'b1;
        cmd(8'h06);
        cmd(8'he8, PW, 64);
        idle();
        check({prog_err, write_enable_latch}, 2'b10);
        prog_fail = 1'b0;
        cmd(8'h30);
        @(negedge clk);
        cont_read_enter = 1'b1;
        @(negedge clk);
        cont_read_enter = 1'b0;
        cmd(8'h06);
        check({cont_read, write_enable_latch}, 2'b10);
        cmd(8'hff);
        cmd(8'h06);
        check({cont_read, write_enable_latch}, 2'b01);
        for (int i = 0; i < 2; i++) begin
            load(8'h08, 3'h5);
            load(8'h08 | 8'(i << 1), 3'h5);
            cmd(8'hf0);
            check(write_in_progress, 1'b1);
            idle();
            check(block_protect, (i == 1) ? 3'h5 : 3'h0);
            check(config_reg_one, 8'h08 | 8'(i << 1));
            check({lock_bit, write_enable_latch}, 2'b10);
        end
        do_reset(16'hfffb);
        check({config_reg_one, lock_bit}, 9'h000);
        cmd(8'h06);
        cmd(8'he8, PW, 64);
        check(write_in_progress, 1'b0);
        cmd(8'he7, 64'h0, 64);
        check(u_fplr_host_model.oe_seen, 1'b0);
        cmd(8'he9, ~PW, 64);
        repeat (150) @(negedge clk);
        check({write_in_progress, prog_err}, 2'b11);
        cmd(8'hf0);
        idle();
        check({write_in_progress, prog_err}, 2'b00);
        summarize();
    end
endmodule : tb_top
